// *** indexed_offset_decode.sv ***
// decode and execute of indexed literal offset byte and bit instructions
`timescale 1ns/10ps
module indexed_offset_decode #(
   parameter int unsigned DW = idx_pkg::DATA_W,
   parameter int unsigned AW = idx_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       reset_n,
   // configuration
   input  wire logic                       extended_set_config_bit,
   // instruction fetch
   input  wire logic                       instr_valid,
   input  wire logic [idx_pkg::OP_W-1:0]   instr_word,
   // core state
   input  wire logic [AW-1:0]              indirect_pointer_two,
   input  wire logic [DW-1:0]              w_in,
   // data memory read port (same cycle)
   output logic      [AW-1:0]              rd_addr,
   input  wire logic [DW-1:0]              rd_data,
   // results
   output idx_pkg::mem_wr_t                mem_wr,
   output logic                            w_wr,
   output logic      [DW-1:0]              w_out,
   output logic                            flags_wr,
   output logic      [4:0]                 flags_out,
   output logic                            handled
);
   // ==========================================
   // decode
   idx_pkg::dec_t dec;
   logic          indexed;
   logic [7:0]    k;

   always_comb begin
      k       = instr_word[7:0];
      // the a bit must be clear and the operand in the low window
      indexed = extended_set_config_bit && !instr_word[idx_pkg::A_BIT]
                && (k <= idx_pkg::OFFS_MAX);
      dec        = '0;
      dec.addr   = indirect_pointer_two + AW'(k);
      dec.to_mem = instr_word[idx_pkg::D_BIT];
      dec.bsel   = instr_word[idx_pkg::BSEL_LSB +: 3];
      if (instr_valid && indexed) begin
         if (instr_word[15:10] == idx_pkg::ADD_TOP)
            dec.kind = idx_pkg::OP_ADD;
         else if (instr_word[15:12] == idx_pkg::BSET_TOP)
            dec.kind = idx_pkg::OP_BSET;
         else if (instr_word[15:8] == idx_pkg::SETA_TOP)
            dec.kind = idx_pkg::OP_SETA;
      end
   end

   assign rd_addr = dec.addr;

   // ==========================================
   // execute
   logic [DW-1:0] sum;
   logic [4:0]    add_flags;

   idx_alu #(.W(DW)) u_alu (
      .a     (w_in),
      .b     (rd_data),
      .sum   (sum),
      .flags (add_flags)
   );

   // results registered; one instruction per cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_wr    <= '0;
         w_wr      <= 1'b0;
         w_out     <= '0;
         flags_wr  <= 1'b0;
         flags_out <= '0;
         handled   <= 1'b0;
      end else begin
         mem_wr.wr   <= 1'b0;
         mem_wr.addr <= dec.addr;
         w_wr        <= 1'b0;
         flags_wr    <= 1'b0;
         handled     <= (dec.kind != idx_pkg::OP_NONE);
         unique case (dec.kind)
            idx_pkg::OP_ADD: begin
               flags_wr  <= 1'b1;
               flags_out <= add_flags;
               if (dec.to_mem) begin
                  mem_wr.wr   <= 1'b1;
                  mem_wr.data <= sum;
               end else begin
                  w_wr  <= 1'b1;
                  w_out <= sum;
               end
            end
            idx_pkg::OP_BSET: begin
               mem_wr.wr   <= 1'b1;
               mem_wr.data <= rd_data | (DW'(1) << dec.bsel);
            end
            idx_pkg::OP_SETA: begin
               mem_wr.wr   <= 1'b1;
               mem_wr.data <= idx_pkg::ALL_ONES;
            end
            idx_pkg::OP_NONE: begin
            end
         endcase
      end
   end

   // ==========================================
   // assertions
   property p_disabled_quiet;
      @(posedge ref_clk) disable iff (!reset_n)
         !extended_set_config_bit |=> !handled && !mem_wr.wr && !w_wr;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("indexed op while disabled");

   property p_high_operand_ignored;
      @(posedge ref_clk) disable iff (!reset_n)
         (instr_word[7:0] > idx_pkg::OFFS_MAX || instr_word[idx_pkg::A_BIT]) |=> !handled;
   endproperty
   a_high_operand_ignored: assert property (p_high_operand_ignored) else $error("operand out of window");

   property p_addr_offset;
      @(posedge ref_clk) disable iff (!reset_n)
         handled |-> mem_wr.addr == $past(indirect_pointer_two) + AW'($past(instr_word[7:0]));
   endproperty
   a_addr_offset: assert property (p_addr_offset) else $error("wrong indexed address");

   sequence s_add_to_w;
      instr_valid && extended_set_config_bit && instr_word[15:8] == 8'h24 && instr_word[7:0] <= 8'h5F;
   endsequence
   property p_add_w;
      @(posedge ref_clk) disable iff (!reset_n)
         s_add_to_w |=> w_wr && flags_wr && !mem_wr.wr && w_out == $past(w_in) + $past(rd_data);
   endproperty
   a_add_w: assert property (p_add_w) else $error("add to W wrong");

   property p_add_mem;
      @(posedge ref_clk) disable iff (!reset_n)
         (instr_valid && extended_set_config_bit && instr_word[15:8] == 8'h26 && instr_word[7:0] <= 8'h5F)
         |=> mem_wr.wr && !w_wr && flags_wr && mem_wr.data == $past(w_in) + $past(rd_data);
   endproperty
   a_add_mem: assert property (p_add_mem) else $error("add to memory wrong");

   property p_bset;
      @(posedge ref_clk) disable iff (!reset_n)
         (dec.kind == idx_pkg::OP_BSET) |=> mem_wr.wr && !flags_wr
            && mem_wr.data[$past(dec.bsel)] && (mem_wr.data | $past(rd_data)) == mem_wr.data;
   endproperty
   a_bset: assert property (p_bset) else $error("bit set wrong");

   property p_seta;
      @(posedge ref_clk) disable iff (!reset_n)
         (dec.kind == idx_pkg::OP_SETA) |=> mem_wr.wr && mem_wr.data == 8'hFF && !flags_wr && !w_wr;
   endproperty
   a_seta: assert property (p_seta) else $error("set all wrong");

   property p_flags_only_add;
      @(posedge ref_clk) disable iff (!reset_n)
         flags_wr |-> $past(dec.kind) == idx_pkg::OP_ADD;
   endproperty
   a_flags_only_add: assert property (p_flags_only_add) else $error("flags written by non-add");

   // ==========================================
   // further checks on the result pulses
   // a result needs a valid word one cycle earlier, so a stale opcode never fires twice
   property p_handled_needs_valid;
      @(posedge ref_clk) disable iff (!reset_n)
         !instr_valid |=> !handled;
   endproperty
   a_handled_needs_valid: assert property (p_handled_needs_valid) else $error("result without valid word");

   // one destination per instruction: W or memory, never both
   property p_write_exclusive;
      @(posedge ref_clk) disable iff (!reset_n)
         !(w_wr && mem_wr.wr);
   endproperty
   a_write_exclusive: assert property (p_write_exclusive) else $error("both destinations written");

   // the decoder itself stays idle while the mode is off
   property p_off_no_kind;
      @(posedge ref_clk) disable iff (!reset_n)
         !extended_set_config_bit |-> dec.kind == idx_pkg::OP_NONE;
   endproperty
   a_off_no_kind: assert property (p_off_no_kind) else $error("decode active while disabled");

   // bit set may change one bit of the old byte at most
   sequence s_bset_issue;
      dec.kind == idx_pkg::OP_BSET;
   endsequence
   property p_bset_one_bit;
      @(posedge ref_clk) disable iff (!reset_n)
         s_bset_issue |=> $onehot0(mem_wr.data ^ $past(rd_data));
   endproperty
   a_bset_one_bit: assert property (p_bset_one_bit) else $error("bit set touched other bits");

   // set all lands on the indexed byte
   sequence s_seta_issue;
      dec.kind == idx_pkg::OP_SETA;
   endsequence
   property p_seta_addr;
      @(posedge ref_clk) disable iff (!reset_n)
         s_seta_issue |=> mem_wr.addr == $past(rd_addr);
   endproperty
   a_seta_addr: assert property (p_seta_addr) else $error("set all wrong address");

   // zero flag follows the truncated sum
   property p_add_zero;
      @(posedge ref_clk) disable iff (!reset_n)
         flags_wr |-> flags_out[idx_pkg::FL_Z] == (DW'($past(w_in) + $past(rd_data)) == '0);
   endproperty
   a_add_zero: assert property (p_add_zero) else $error("zero flag wrong");

   // carry is the ninth bit of the sum
   property p_add_carry;
      @(posedge ref_clk) disable iff (!reset_n)
         flags_wr |-> flags_out[idx_pkg::FL_C] == (({1'b0, $past(w_in)} + {1'b0, $past(rd_data)}) >> DW);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("carry flag wrong");
endmodule // indexed_offset_decode

// *** idx_pkg.sv ***
// package: encodings, widths and constants for the indexed offset decoder
package idx_pkg;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned OP_W      = 16;
   localparam logic [7:0]  OFFS_MAX  = 8'h5F;
   localparam logic [7:0]  ALL_ONES  = 8'hFF;
   // opcode fields
   localparam logic [5:0]  ADD_TOP   = 6'h09;   // 0010 01
   localparam logic [3:0]  BSET_TOP  = 4'h8;    // 1000
   localparam logic [7:0]  SETA_TOP  = 8'h68;   // 0110 1000
   localparam int unsigned D_BIT     = 9;
   localparam int unsigned A_BIT     = 8;
   localparam int unsigned BSEL_LSB  = 9;
   // status flag bit positions
   localparam int unsigned FL_C  = 0;
   localparam int unsigned FL_DC = 1;
   localparam int unsigned FL_Z  = 2;
   localparam int unsigned FL_OV = 3;
   localparam int unsigned FL_N  = 4;

   typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_BSET, OP_SETA} op_kind_t;

   typedef struct packed {
      op_kind_t          kind;
      logic              to_mem;
      logic [2:0]        bsel;
      logic [ADDR_W-1:0] addr;
   } dec_t;

   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mem_wr_t;
endpackage

// *** idx_alu.sv ***
// add unit with status flag generation
`timescale 1ns/10ps
module idx_alu #(
   parameter int unsigned W = 8
) (
   // operands
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   // results
   output logic      [W-1:0] sum,
   output logic      [4:0]   flags
);
   logic [W:0]   wide;
   logic [4:0]   low_nib;

   always_comb begin
      wide    = {1'b0, a} + {1'b0, b};
      low_nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      sum     = wide[W-1:0];
      flags   = '0;
      flags[idx_pkg::FL_C]  = wide[W];
      flags[idx_pkg::FL_DC] = low_nib[4];
      flags[idx_pkg::FL_Z]  = (wide[W-1:0] == '0);
      flags[idx_pkg::FL_OV] = (a[W-1] == b[W-1]) && (wide[W-1] != a[W-1]);
      flags[idx_pkg::FL_N]  = wide[W-1];
   end
endmodule // idx_alu

// *** tb_top.sv ***
// testbench: indexed offset decoder, byte and bit ops
`timescale 1ns/10ps
module tb_top;
   // ==========================
   // signals
   logic                   ref_clk;
   logic                   reset_n;
   logic                   extended_set_config_bit;
   logic                   instr_valid;
   logic [15:0]            instr_word;
   logic [11:0]            indirect_pointer_two;
   logic [7:0]             w_in;
   logic [11:0]            rd_addr;
   logic [7:0]             rd_data;
   idx_pkg::mem_wr_t       mem_wr;
   logic                   w_wr;
   logic [7:0]             w_out;
   logic                   flags_wr;
   logic [4:0]             flags_out;
   logic                   handled;
   int                     errors;
   int                     compares;

   indexed_offset_decode indexed_offset_decode_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .extended_set_config_bit(extended_set_config_bit), .instr_valid(instr_valid),
      .instr_word(instr_word), .indirect_pointer_two(indirect_pointer_two), .w_in(w_in),
      .rd_addr(rd_addr), .rd_data(rd_data), .mem_wr(mem_wr), .w_wr(w_wr), .w_out(w_out),
      .flags_wr(flags_wr), .flags_out(flags_out), .handled(handled));

   // memory model: contents follow the low address byte, so a wrong low address byte shows as wrong data
   assign rd_data = rd_addr[7:0] ^ 8'hA5;

   always #12.5 ref_clk = ~ref_clk;

   // ==========================
   // helpers
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // kind: 0 refused, 1 add, 2 bit set, 3 set all
   task automatic run_op(input logic [15:0] op, input logic cfg, input logic [1:0] kind,
                         input logic [11:0] p, input logic [7:0] w);
      logic [11:0] ea;
      logic [7:0]  md;
      logic [7:0]  ev;
      logic [8:0]  s9;
      logic [4:0]  fl;
      ea = p + {4'h0, op[7:0]};
      md = ea[7:0] ^ 8'hA5;
      s9 = {1'b0, md} + {1'b0, w};
      fl = {s9[7], (md[7] == w[7]) && (s9[7] != md[7]), s9[7:0] == 8'h00,
            ({1'b0, md[3:0]} + {1'b0, w[3:0]}) > 5'h0F, s9[8]};
      ev = (kind == 2'd1) ? s9[7:0] : (kind == 2'd2) ? (md | (8'h01 << op[11:9])) : 8'hFF;
      @(posedge ref_clk);
      extended_set_config_bit <= cfg;
      instr_word              <= op;
      indirect_pointer_two    <= p;
      w_in                    <= w;
      instr_valid             <= 1'b1;
      #1;
      if (kind != 2'd0) chk("rd_addr", ea, rd_addr);
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
      chk("handled", kind != 2'd0, handled);
      chk("w_wr", kind == 2'd1 && !op[9], w_wr);
      chk("mem_wr.wr", kind > 2'd1 || (kind == 2'd1 && op[9]), mem_wr.wr);
      chk("flags_wr", kind == 2'd1, flags_wr);
      if (kind == 2'd1) chk("flags_out", fl, flags_out);
      if (kind == 2'd1 && !op[9]) chk("w_out", ev, w_out);
      if (kind > 2'd1 || (kind == 2'd1 && op[9])) chk("mem_wr.addr", ea, mem_wr.addr);
      if (kind > 2'd1 || (kind == 2'd1 && op[9])) chk("mem_wr.data", ev, mem_wr.data);
   endtask

   // ==========================
   // scenarios
   task automatic t_add;
      run_op(16'h245F, 1'b1, 2'd1, 12'h0A00, 8'h06);
      run_op(16'h245F, 1'b1, 2'd1, 12'h0A00, 8'h80);
      run_op(16'h262C, 1'b1, 2'd1, 12'h0A00, 8'h17);
      run_op(16'h2600, 1'b1, 2'd1, 12'h0FF0, 8'h01);
      $display("add test done");
   endtask

   task automatic t_bset;
      for (int b = 0; b < 8; b++) begin
         run_op({4'h8, b[2:0], 1'b0, 8'h0A}, 1'b1, 2'd2, 12'h0A00, 8'h33);
      end
      $display("bit set test done");
   endtask

   task automatic t_seta;
      run_op(16'h685F, 1'b1, 2'd3, 12'h0A00, 8'h00);
      run_op(16'h6800, 1'b1, 2'd3, 12'h0123, 8'h00);
      $display("set all test done");
   endtask

   // ignored cases: mode off, access bit set, offset past the window
   task automatic t_refuse;
      run_op(16'h2405, 1'b0, 2'd0, 12'h0A00, 8'h17);
      run_op(16'h6810, 1'b0, 2'd0, 12'h0A00, 8'h17);
      run_op(16'h2505, 1'b1, 2'd0, 12'h0A00, 8'h17);
      run_op(16'h8060, 1'b1, 2'd0, 12'h0A00, 8'h17);
      run_op(16'h6860, 1'b1, 2'd0, 12'h0A00, 8'h17);
      $display("refuse test done");
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================
   // main sequence
   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      extended_set_config_bit = 1'b0;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      indirect_pointer_two = 12'h000;
      w_in = 8'h00;
      errors = 0;
      compares = 0;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_add();
      t_bset();
      t_seta();
      t_refuse();
      wrap_up();
   end
endmodule // tb_top
